// *** rtl/fom_pkg.sv ***
// Package for the frame offset measurement and offset programming block.
// Assumes an APB slave with 32-bit data and word-indexed register offsets.
package fom_pkg;
  // Printed offsets are word indexes; byte address is four times the index.
  localparam logic [7:0]  IDX_CTRL     = 8'h01; // Holds the start evaluation bit.
  localparam logic [7:0]  IDX_RESULT   = 8'h02;
  localparam logic [7:0]  IDX_OFS_0_3  = 8'h04;
  localparam logic [7:0]  IDX_OFS_4_7  = 8'h05;
  localparam logic [7:0]  IDX_OFS_8_11 = 8'h06;
  localparam int          ADDR_W       = 12;
  localparam int          REG_W        = 16;
  localparam int          NUM_OFS      = 3;
  // Field positions.
  localparam int          BIT_START    = 2;
  localparam int          BIT_GCI      = 0; // Control bit selecting GCI pulse polarity.
  localparam int          BIT_DONE     = 12;
  localparam int          BIT_HALF     = 11;
  localparam int          DELAY_W      = 11;
  localparam logic [15:0] RESULT_RST   = 16'h0000;
  localparam logic [15:0] OFS_RST      = 16'h0000;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  // Measurement window: frame pulse edge expected within this many clocks.
  localparam int          FRAME_CLKS   = 2048;
  localparam int          FRAME_W      = 12;
  typedef enum logic [1:0] {FOM_IDLE, FOM_WAIT, FOM_DONE} fom_state_t;
endpackage : fom_pkg

// *** rtl/fom_sync.sv ***
// Three-stage synchroniser for an asynchronous pin.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module fom_sync (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Pin side.
  input  wire logic async_i,
  // Synchronised outputs.
  output logic      sync_o,
  output logic      stable_o
);
  logic [2:0] stage;
  logic [2:0] next_stage;

  // Shift the pin in; the first stage is read only by the second.
  always_comb begin
    next_stage = {stage[1:0], async_i};
  end

  // Register the stages.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= 3'h0;
    end else begin
      stage <= next_stage;
    end
  end

  // A value counts only when the second and third stages agree.
  assign sync_o   = stage[2];
  assign stable_o = (stage[2] == stage[1]);
endmodule : fom_sync

// *** rtl/fom_top.sv ***
// Frame offset measurement and per-stream input offset registers, APB slave.
// Assumes the frame pulse pin is asynchronous and the link clock is sampled as a pin.
// Operation
// R1 - Software keeps result bits 15-13 at zero
// R2 - Done flag sets when measurement finishes
// R3 - Start bit falling clears done flag (here a result landing in the same cycle sets it instead)
// R4 - Bit 11 reports clock phase at edge
// R5 - Delay field is unsigned eleven-bit count
// R6 - Start bit falling clears delay field (here a result landing in the same cycle is loaded instead)
// R7 - Result register read-only, resets to zero
// R8 - Offset registers pack four streams each
// R9 - Start bit rising begins an evaluation
// R10 - Offset bits delay frame start capture
// R11 - Latch edge bit selects sampling edge
// R12 - Software derives offsets from measurement
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module fom_top #(
  parameter int FRAME_CLKS = fom_pkg::FRAME_CLKS
) (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Frame evaluation pulse and the serial link clock, both from pins.
  input  wire logic        frame_evaluation_input_i,
  input  wire logic        link_clk_i,
  // Per-stream settings toward the receivers.
  output logic [2:0]       stream_offset_bits_o [12],
  output logic [11:0]      stream_latch_edge_bit_o
);
  logic rst_q1, rst_q2;
  logic pulse_sync, pulse_stable, lc_sync, lc_stable;
  logic pulse_prev, next_pulse_prev;
  logic [15:0] ctrl, next_ctrl;
  logic [15:0] ofs [fom_pkg::NUM_OFS];
  logic [15:0] next_ofs [fom_pkg::NUM_OFS];
  logic evaluation_complete_flag, next_done;
  logic half_cycle_phase_bit, next_half;
  logic [fom_pkg::DELAY_W-1:0] frame_delay_count, next_delay;
  logic [fom_pkg::FRAME_W-1:0] window, next_window;
  fom_pkg::fom_state_t state, next_state;
  logic start_prev, next_start_prev;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic [2:0]  next_ofs_o [12];
  logic [11:0] next_edge_o;
  logic        access, wr, start_rise, start_fall, pulse_edge;
  logic [7:0]  idx;

  // Release reset through two flops so every register leaves reset together.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Both pins pass the three-stage synchroniser.
  fom_sync u_pulse_sync (
    .clk_i    (clock_i),
    .rst_n_i  (rst_q2),
    .async_i  (frame_evaluation_input_i),
    .sync_o   (pulse_sync),
    .stable_o (pulse_stable)
  );
  fom_sync u_lc_sync (
    .clk_i    (clock_i),
    .rst_n_i  (rst_q2),
    .async_i  (link_clk_i),
    .sync_o   (lc_sync),
    .stable_o (lc_stable)
  );

  // Word index from the byte address; misaligned addresses decode to nothing.
  function automatic logic [7:0] word_idx(input logic [11:0] a);
    word_idx = (a[1:0] == 2'b00) ? a[9:2] : 8'hff;
  endfunction : word_idx

  // Byte-lane merge for the 16 low data bits.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  assign idx        = word_idx(paddr_i);
  assign access     = psel_i && penable_i && !pready_o;
  assign wr         = access && pwrite_i;
  assign start_rise = ctrl[fom_pkg::BIT_START] && !start_prev; // see R9
  assign start_fall = !ctrl[fom_pkg::BIT_START] && start_prev; // see R3
  // Falling pulse edge normally, rising edge in GCI mode; only agreed values count.
  assign pulse_edge = pulse_stable && (pulse_sync != pulse_prev) &&
                      (ctrl[fom_pkg::BIT_GCI] ? pulse_sync : !pulse_sync); // see R4

  // Register writes. The result register takes no write, being read-only.
  always_comb begin
    next_ctrl = ctrl;
    for (int i = 0; i < fom_pkg::NUM_OFS; i++) begin
      next_ofs[i] = ofs[i];
    end
    if (wr && idx == fom_pkg::IDX_CTRL) begin
      next_ctrl = merge16(ctrl, pwdata_i, pstrb_i);
    end
    if (wr && idx == fom_pkg::IDX_OFS_0_3) begin
      next_ofs[0] = merge16(ofs[0], pwdata_i, pstrb_i);
    end
    if (wr && idx == fom_pkg::IDX_OFS_4_7) begin
      next_ofs[1] = merge16(ofs[1], pwdata_i, pstrb_i);
    end
    if (wr && idx == fom_pkg::IDX_OFS_8_11) begin
      next_ofs[2] = merge16(ofs[2], pwdata_i, pstrb_i);
    end
  end

  // Measurement: count clocks from the start until the chosen pulse edge.
  always_comb begin
    next_state      = state;
    next_done       = evaluation_complete_flag;
    next_half       = half_cycle_phase_bit;
    next_delay      = frame_delay_count;
    next_window     = window;
    next_start_prev = ctrl[fom_pkg::BIT_START];
    next_pulse_prev = pulse_stable ? pulse_sync : pulse_prev;
    case (state)
      fom_pkg::FOM_IDLE: begin
        if (start_rise) begin
          next_state  = fom_pkg::FOM_WAIT; // see R9
          next_delay  = '0;
          next_done   = 1'b0;
          next_half   = 1'b0;
          next_window = '0;
        end
      end
      fom_pkg::FOM_WAIT: begin
        next_window = window + 1'b1;
        if (pulse_edge) begin
          next_state = fom_pkg::FOM_DONE;
          next_done  = 1'b1; // see R2
          next_half  = lc_sync; // see R4
          next_delay = window[fom_pkg::DELAY_W-1:0]; // see R5
        end else if (window == fom_pkg::FRAME_W'(FRAME_CLKS - 1)) begin
          next_window = '0; // A frame with no pulse; keep looking.
        end
      end
      fom_pkg::FOM_DONE: begin
        next_state = fom_pkg::FOM_DONE;
      end
      default: begin
        next_state = fom_pkg::FOM_IDLE;
      end
    endcase
    // Dropping the start bit aborts or ends any evaluation. A result landing in
    // that same cycle wins over the clear, so a finished measurement is not lost.
    if (start_fall) begin
      next_state = fom_pkg::FOM_IDLE;
      if (!(state == fom_pkg::FOM_WAIT && pulse_edge)) begin
        next_done  = 1'b0; // see R3
        next_delay = '0; // see R6
      end
    end
  end

  // APB answer: one wait state, errors for unmapped or result-register writes.
  always_comb begin
    next_pready  = access;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (access) begin
      case (idx)
        fom_pkg::IDX_CTRL:     next_prdata = {16'h0000, ctrl};
        // Bits 15-13 always read as zero.
        fom_pkg::IDX_RESULT: begin
          next_prdata = {19'h00000, evaluation_complete_flag, half_cycle_phase_bit, frame_delay_count}; // see R7
          next_pslverr = pwrite_i; // see R7
        end
        fom_pkg::IDX_OFS_0_3:  next_prdata = {16'h0000, ofs[0]};
        fom_pkg::IDX_OFS_4_7:  next_prdata = {16'h0000, ofs[1]};
        fom_pkg::IDX_OFS_8_11: next_prdata = {16'h0000, ofs[2]};
        default:               next_pslverr = 1'b1;
      endcase
    end
  end

  // Unpack stream settings: stream 4k+j sits at bits 4j+3..4j of register k.
  always_comb begin
    for (int s = 0; s < 12; s++) begin
      next_ofs_o[s]  = ofs[s/4][(s%4)*4+1 +: 3]; // see R8 see R10
      next_edge_o[s] = ofs[s/4][(s%4)*4]; // see R8 see R11
    end
  end

  // Register everything.
  always_ff @(posedge clock_i or negedge rst_q2) begin
    if (!rst_q2) begin
      ctrl                     <= fom_pkg::CTRL_RST;
      for (int i = 0; i < fom_pkg::NUM_OFS; i++) begin
        ofs[i] <= fom_pkg::OFS_RST;
      end
      state                    <= fom_pkg::FOM_IDLE;
      evaluation_complete_flag <= fom_pkg::RESULT_RST[fom_pkg::BIT_DONE];
      half_cycle_phase_bit     <= fom_pkg::RESULT_RST[fom_pkg::BIT_HALF];
      frame_delay_count        <= fom_pkg::RESULT_RST[fom_pkg::DELAY_W-1:0];
      window                   <= '0;
      start_prev               <= 1'b0;
      pulse_prev               <= 1'b0; // Matches the synchroniser's reset level.
      pready_o                 <= 1'b0;
      pslverr_o                <= 1'b0;
      prdata_o                 <= 32'h00000000;
      stream_latch_edge_bit_o  <= 12'h000;
      for (int s = 0; s < 12; s++) begin
        stream_offset_bits_o[s] <= 3'h0;
      end
    end else begin
      ctrl                     <= next_ctrl;
      ofs                      <= next_ofs;
      state                    <= next_state;
      evaluation_complete_flag <= next_done;
      half_cycle_phase_bit     <= next_half;
      frame_delay_count        <= next_delay;
      window                   <= next_window;
      start_prev               <= next_start_prev;
      pulse_prev               <= next_pulse_prev;
      pready_o                 <= next_pready;
      pslverr_o                <= next_pslverr;
      prdata_o                 <= next_prdata;
      stream_latch_edge_bit_o  <= next_edge_o;
      stream_offset_bits_o     <= next_ofs_o;
    end
  end
endmodule : fom_top

// *** tb/fom_properties.sv ***
// Checker for fom_top: APB answers, result fields and stream mapping.
// Assumes byte address is four times the word index.
`timescale 1ns/1ps
module fom_properties #(parameter int FRAME_CLKS = 2048) (
  // Top module ports, watched only.
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [11:0] paddr_i,
  input wire logic [11:0] stream_latch_edge_bit_o,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic [2:0]  stream_offset_bits_o [12]
);
  logic acc, rd, wr, start_q;
  // A copy of the start bit, so that clears are judged without internals.
  assign acc = psel_i && penable_i && pready_o;
  assign rd = acc && !pwrite_i;
  assign wr = acc && pwrite_i && !pslverr_o;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) start_q <= 1'b0;
    else if (wr && paddr_i == 12'h004) start_q <= pwdata_i[2];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_res; rd && paddr_i == 12'h008; endsequence
  sequence wr_ofs; wr && paddr_i == 12'h010; endsequence
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("long pready");
  ready_cause_a: assert property ($rose(pready_o) |-> $past(psel_i && penable_i))
    else $error("stray pready");
  result_ro_a: assert property (acc && pwrite_i && paddr_i == 12'h008 |-> pslverr_o)
    else $error("result written");
  bad_addr_a: assert property (acc && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("misaligned taken");
  result_top_a: assert property (rd_res |-> prdata_o[31:13] == 19'h0)
    else $error("upper bits set");
  clear_done_a: assert property (rd_res ##0 !start_q |-> (prdata_o & 32'h17ff) == 32'h0)
    else $error("result not cleared");
  done_start_a: assert property (rd_res ##0 prdata_o[12] |-> start_q)
    else $error("done unasked");
  ofs_map_a: assert property (wr_ofs |=> stream_offset_bits_o[0] == $past(pwdata_i[3:1])
    && stream_latch_edge_bit_o[3] == $past(pwdata_i[12])) else $error("field misplaced");
endmodule : fom_properties
bind fom_top fom_properties #(.FRAME_CLKS(FRAME_CLKS)) chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .stream_offset_bits_o(stream_offset_bits_o),
  .stream_latch_edge_bit_o(stream_latch_edge_bit_o));

// *** tb/fom_pulse_src.sv ***
// Far-side model: frame evaluation pulse source and link clock pin.
// Assumes the bench raises arm_i as a start write completes.
`timescale 1ns/1ps
module fom_pulse_src (
  // Bench controls.
  input  wire logic       clock_i,
  input  wire logic       arm_i,
  input  wire logic       gci_i,
  input  wire logic       lvl_i,
  input  wire logic [7:0] dly_i,
  // Pins toward the block.
  output logic            pulse_o,
  output logic            lclk_o
);
  logic [7:0] cnt;
  // Saturating count, so no second pulse edge appears.
  always @(posedge clock_i) begin
    if (!arm_i) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  // Idles high, or low in GCI mode, and turns dly_i clocks after arming.
  assign pulse_o = (arm_i && cnt >= dly_i) ? gci_i : !gci_i;
  // The link clock stands still at the level the bench picks.
  assign lclk_o = lvl_i;
endmodule : fom_pulse_src

// *** tb/tb.sv ***
// Bench for fom_top: registers, stream fields and frame measurement.
// Assumes fom_pulse_src drives the pulse and link clock pins.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t mismatch %h/%h", $time, a, b); end end
module tb;
  logic clock_i, rst_n_i, psel, penable, pwrite, pready, err, er, arm, gci, lvl, pulse, lck;
  logic [3:0] strb;
  logic [11:0] addr, dle;
  logic [31:0] wd, prd, rd;
  logic [15:0] v;
  logic [7:0] dly;
  logic [2:0] ofs [12];
  int fail_count, checks_done;
  // A short window keeps the run brief.
  fom_top #(.FRAME_CLKS(64)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(addr), .pwdata_i(wd), .pstrb_i(strb), .pready_o(pready), .prdata_o(prd),
    .pslverr_o(err), .frame_evaluation_input_i(pulse), .link_clk_i(lck), .stream_offset_bits_o(ofs),
    .stream_latch_edge_bit_o(dle));
  fom_pulse_src src (.clock_i(clock_i), .arm_i(arm), .gci_i(gci), .lvl_i(lvl), .dly_i(dly), .pulse_o(pulse),
    .lclk_o(lck));
  // Free-running 50 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Verdict; also reached from a wait that ran out.
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i) {psel, pwrite, addr, wd} <= {1'b1, w, a, d};
    @(posedge clock_i) penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prd;
    er = err;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask : apb
  // Software's setting from a measurement: delay bits, inverse phase bit.
  function automatic logic [15:0] derive(input logic [31:0] r);
    return {12'h000, r[2:0], ~r[11]};
  endfunction : derive
  // The four stream fields of register k follow from the written word.
  task automatic chk_ofs(input int k, input logic [15:0] d);
    repeat (2) @(posedge clock_i);
    for (int j = 0; j < 4; j++) begin
      `CHK(ofs[4*k+j], d[4*j+1 +: 3])
      `CHK(dle[4*k+j], d[4*j])
    end
  endtask : chk_ofs
  // Reset, register access, random fields, then a measurement per mode.
  initial begin
    {rst_n_i, psel, penable, pwrite, arm, gci, lvl, addr, wd, dly} = '0;
    strb = 4'h3;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(55));
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    apb(1'b1, 12'h008, 32'hffff);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h0fd, 32'h0);
    `CHK(er, 1'b1)
    for (int i = 0; i < 9; i++) begin
      v = (i < 3) ? 16'hffff : 16'($urandom);
      apb(1'b1, 12'h010 + 12'(4 * (i % 3)), {16'h0, v});
      chk_ofs(i % 3, v);
      apb(1'b0, 12'h010 + 12'(4 * (i % 3)), 32'h0);
      `CHK(rd, {16'h0, v})
    end
    // Upper byte lane alone: the low byte of the register keeps its value.
    strb <= 4'h2;
    apb(1'b1, 12'h018, 32'h0000a55a);
    strb <= 4'h3;
    v = {8'ha5, v[7:0]};
    chk_ofs(2, v);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd, {16'h0, v})
    for (int m = 0; m < 4; m++) begin
      {gci, lvl} <= 2'(m);
      dly <= 8'(5 + $urandom % 30);
      repeat (64) @(posedge clock_i);
      rd = 32'h0;
      apb(1'b1, 12'h004, 32'h4 | 32'(m / 2));
      arm <= 1'b1;
      for (int p = 0; p < 40 && rd[12] !== 1'b1; p++)
        apb(1'b0, 12'h008, 32'h0);
      `CHK(rd[12], 1'b1)
      if (rd[12] !== 1'b1) summarize();
      `CHK(rd[11], lvl)
      `CHK(rd[10:0] >= 11'(dly) && rd[10:0] <= 11'(dly) + 11'h8, 1'b1)
      v = derive(rd);
      apb(1'b1, 12'h018, {16'h0, v});
      chk_ofs(2, v);
      apb(1'b1, 12'h004, 32'(m / 2));
      arm <= 1'b0;
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd & 32'h17ff, 32'h0)
    end
    // A second reset in mid-run: the kept phase bit, all latch edge bits, stream 0's offset bits and register 0x010 return to zero.
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    `CHK(dle, 12'h000)
    `CHK(ofs[0], 3'h0)
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'h0)
    summarize();
  end
endmodule : tb
